// ===== core/lsau_params.svh
// Constants for the load/store address unit
`ifndef LSAU_PARAMS_SVH
`define LSAU_PARAMS_SVH
`define LSAU_WORD_STEP 32'h0000_0004
`define LSAU_MAX_SHIFT 2'h3
`define LSAU_PC_REL_MAX 32'h0000_0fff
`define LSAU_PAIR_MAX 32'h0000_03fc
`define LSAU_UNPRIV_MAX 8'hff
`define LSAU_REG_SP 4'hd
`define LSAU_REG_LR 4'he
`define LSAU_REG_PC 4'hf
`define LSAU_BYTE_SIGN 7
`define LSAU_HALF_SIGN 15
`define LSAU_PAIR_SECOND 32'h0000_0004
`endif

// ===== core/lsau_pkg.sv
// Types for the load/store address unit
package lsau_pkg;
    typedef enum logic [2:0] {
        OP_LOAD_REGOFF = 3'h0,
        OP_STORE_REGOFF = 3'h1,
        OP_LOAD_UNPRIV = 3'h2,
        OP_STORE_UNPRIV = 3'h3,
        OP_LOAD_PCREL = 3'h4,
        OP_LOAD_PAIR_PCREL = 3'h5,
        OP_LOAD_MULTIPLE = 3'h6,
        OP_STORE_MULTIPLE = 3'h7
    } lsau_op_type;

    // Multiple-transfer mode including the stack synonyms
    typedef enum logic [2:0] {
        MODE_DEFAULT = 3'h0,
        MODE_INC_AFTER = 3'h1,
        MODE_DEC_BEFORE = 3'h2,
        MODE_FD_POP = 3'h3,
        MODE_EA_POP = 3'h4,
        MODE_EA_PUSH = 3'h5,
        MODE_FD_PUSH = 3'h6
    } lsau_mode_type;

    typedef enum logic [1:0] {
        SIZE_WORD = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_BYTE = 2'h2
    } lsau_size_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ACCESS = 2'h1,
        ST_WAIT = 2'h2,
        ST_FINISH = 2'h3
    } lsau_state_type;

    typedef struct packed {
        lsau_op_type op;
        lsau_mode_type mode;
        lsau_size_type size;
        logic is_signed;
        logic writeback;
        logic privileged;
        logic [3:0] transfer_reg;
        logic [3:0] second_transfer_reg;
        logic [3:0] base_reg;
        logic [1:0] shift_left_amount;
        logic [31:0] base_val;
        logic [31:0] offset_val;
        logic [31:0] pc_val;
        logic [15:0] register_set;
        logic [31:0] store_set_data;
    } lsau_cmd_type;

    typedef struct packed {
        logic req;
        logic write;
        logic unpriv;
        lsau_size_type size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } lsau_mem_type;

    typedef struct packed {
        logic we;
        logic [3:0] idx;
        logic [31:0] data;
    } lsau_wb_type;

    typedef struct packed {
        lsau_state_type state;
        lsau_cmd_type cmd;
        logic incr;
        logic [15:0] remaining;
        logic [31:0] addr;
        logic [31:0] final_addr;
        logic [3:0] cur_reg;
        logic pair_second;
        lsau_mem_type mem;
        lsau_wb_type wb;
        logic branch;
        logic [31:0] branch_target;
        logic busy;
        logic done;
    } lsau_state_all_type;
endpackage

// ===== core/lsau_unit.sv
// Load/store address generation, extension, writeback and branch
`timescale 1ns/10ps
`include "lsau_params.svh"
module lsau_unit (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire logic i_cmd_valid,
    input wire lsau_pkg::lsau_cmd_type i_cmd,
    input wire logic i_mem_ready,
    input wire logic i_rdata_valid,
    input wire logic [31:0] i_rdata,
    output logic o_busy,
    output logic o_done,
    output lsau_pkg::lsau_mem_type o_mem,
    output lsau_pkg::lsau_wb_type o_wb,
    output logic o_branch,
    output logic [31:0] o_branch_target,
    output logic o_flags_we
);
    lsau_pkg::lsau_state_all_type r;
    lsau_pkg::lsau_state_all_type next_r;

    // Widen a loaded value by size and signedness
    function automatic logic [31:0] extend(input logic [31:0] d,
                                           input lsau_pkg::lsau_size_type sz,
                                           input logic sgn);
        logic [31:0] res;
        res = d;
        case (sz)
            lsau_pkg::SIZE_BYTE: begin
                res = {{24{sgn & d[`LSAU_BYTE_SIGN]}}, d[7:0]};
            end
            lsau_pkg::SIZE_HALF: begin
                res = {{16{sgn & d[`LSAU_HALF_SIGN]}}, d[15:0]};
            end
            default: begin
                res = d;
            end
        endcase
        return res;
    endfunction

    // Index of lowest or highest set bit
    function automatic logic [3:0] pick_reg(input logic [15:0] set, input logic low);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < 16; i++) begin
            // Lowest pick takes only a bit with nothing set below it
            if (set[i] && (!low || (set & ((16'h1 << i) - 16'h1)) == 16'h0)) begin
                idx = 4'(i);
            end
        end
        if (low && set[0]) begin
            idx = 4'h0;
        end
        return idx;
    endfunction

    // Number of registers in a set
    function automatic logic [31:0] count_regs(input logic [15:0] set);
        logic [31:0] n;
        n = 32'h0;
        for (int i = 0; i < 16; i++) begin
            n = n + {31'h0, set[i]};
        end
        return n;
    endfunction

    // Clamp a signed program-counter-relative offset
    function automatic logic [31:0] clamp(input logic [31:0] off, input logic [31:0] lim);
        logic [31:0] res;
        res = off;
        if (!off[31] && off > lim) begin
            res = lim;
        end else if (off[31] && (32'h0 - off) > lim) begin
            res = 32'h0 - lim;
        end
        return res;
    endfunction

    // Next-state logic for all transfer forms
    always_comb begin
        logic [31:0] addr;
        logic [31:0] n;
        logic is_load;
        logic [31:0] ext;
        addr = 32'h0;
        n = 32'h0;
        is_load = 1'b0;
        ext = 32'h0;
        next_r = r;
        next_r.done = 1'b0;
        next_r.wb.we = 1'b0;
        next_r.branch = 1'b0;
        case (r.state)
            lsau_pkg::ST_IDLE: begin
                if (i_cmd_valid) begin
                    next_r.cmd = i_cmd;
                    next_r.busy = 1'b1;
                    next_r.pair_second = 1'b0;
                    next_r.remaining = i_cmd.register_set;
                    case (i_cmd.op)
                        lsau_pkg::OP_LOAD_REGOFF, lsau_pkg::OP_STORE_REGOFF: begin
                            // Offset register shifted 0..3, neither source written
                            addr = i_cmd.base_val +
                                   (i_cmd.offset_val << (i_cmd.shift_left_amount &
                                                         `LSAU_MAX_SHIFT));
                        end
                        lsau_pkg::OP_LOAD_UNPRIV, lsau_pkg::OP_STORE_UNPRIV: begin
                            // Omitted offset arrives as zero
                            addr = i_cmd.base_val +
                                   {24'h0, i_cmd.offset_val[7:0] & `LSAU_UNPRIV_MAX};
                        end
                        lsau_pkg::OP_LOAD_PCREL: begin
                            addr = i_cmd.pc_val +
                                   clamp(i_cmd.offset_val, `LSAU_PC_REL_MAX);
                        end
                        lsau_pkg::OP_LOAD_PAIR_PCREL: begin
                            addr = i_cmd.pc_val +
                                   clamp(i_cmd.offset_val, `LSAU_PAIR_MAX);
                        end
                        default: begin
                            // Stack synonyms fold into the two base modes
                            n = count_regs(i_cmd.register_set);
                            if (i_cmd.mode == lsau_pkg::MODE_DEC_BEFORE ||
                                i_cmd.mode == lsau_pkg::MODE_EA_POP ||
                                i_cmd.mode == lsau_pkg::MODE_FD_PUSH) begin
                                next_r.incr = 1'b0;
                                next_r.final_addr = i_cmd.base_val -
                                                    `LSAU_WORD_STEP * (n - 32'h1);
                                addr = i_cmd.base_val;
                                next_r.cur_reg = pick_reg(i_cmd.register_set, 1'b0);
                            end else begin
                                next_r.incr = 1'b1;
                                next_r.final_addr = i_cmd.base_val +
                                                    `LSAU_WORD_STEP * (n - 32'h1);
                                addr = i_cmd.base_val;
                                next_r.cur_reg = pick_reg(i_cmd.register_set, 1'b1);
                            end
                        end
                    endcase
                    next_r.addr = addr;
                    next_r.state = lsau_pkg::ST_ACCESS;
                end
            end
            lsau_pkg::ST_ACCESS: begin
                is_load = (r.cmd.op != lsau_pkg::OP_STORE_REGOFF &&
                           r.cmd.op != lsau_pkg::OP_STORE_UNPRIV &&
                           r.cmd.op != lsau_pkg::OP_STORE_MULTIPLE);
                next_r.mem.req = 1'b1;
                next_r.mem.write = !is_load;
                next_r.mem.addr = r.addr;
                next_r.mem.wdata = r.cmd.store_set_data;
                // Unprivileged only bites when the core is privileged
                next_r.mem.unpriv = (r.cmd.op == lsau_pkg::OP_LOAD_UNPRIV ||
                                     r.cmd.op == lsau_pkg::OP_STORE_UNPRIV) ||
                                    !r.cmd.privileged;
                next_r.mem.size = (r.cmd.op == lsau_pkg::OP_LOAD_MULTIPLE ||
                                   r.cmd.op == lsau_pkg::OP_STORE_MULTIPLE ||
                                   r.cmd.op == lsau_pkg::OP_LOAD_PAIR_PCREL) ?
                                  lsau_pkg::SIZE_WORD : r.cmd.size;
                if (r.mem.req && i_mem_ready) begin
                    next_r.mem.req = 1'b0;
                    next_r.state = is_load ? lsau_pkg::ST_WAIT : lsau_pkg::ST_FINISH;
                end
            end
            lsau_pkg::ST_WAIT: begin
                if (i_rdata_valid) begin
                    ext = extend(i_rdata, r.mem.size, r.cmd.is_signed);
                    next_r.wb.we = 1'b1;
                    next_r.wb.idx = (r.cmd.op == lsau_pkg::OP_LOAD_MULTIPLE) ? r.cur_reg :
                                    (r.pair_second ? r.cmd.second_transfer_reg :
                                     r.cmd.transfer_reg);
                    next_r.wb.data = ext;
                    if (next_r.wb.idx == `LSAU_REG_PC) begin
                        next_r.branch = 1'b1;
                        next_r.branch_target = {ext[31:1], 1'b0};
                    end
                    next_r.state = lsau_pkg::ST_FINISH;
                end
            end
            default: begin
                // Advance to the next word or close the instruction
                next_r.remaining[r.cur_reg] = 1'b0;
                if (r.cmd.op == lsau_pkg::OP_LOAD_PAIR_PCREL && !r.pair_second) begin
                    next_r.pair_second = 1'b1;
                    next_r.addr = r.addr + `LSAU_PAIR_SECOND;
                    next_r.state = lsau_pkg::ST_ACCESS;
                end else if ((r.cmd.op == lsau_pkg::OP_LOAD_MULTIPLE ||
                              r.cmd.op == lsau_pkg::OP_STORE_MULTIPLE) &&
                             next_r.remaining != 16'h0) begin
                    next_r.cur_reg = pick_reg(next_r.remaining, r.incr);
                    next_r.addr = r.incr ? r.addr + `LSAU_WORD_STEP :
                                  r.addr - `LSAU_WORD_STEP;
                    next_r.state = lsau_pkg::ST_ACCESS;
                end else begin
                    if ((r.cmd.op == lsau_pkg::OP_LOAD_MULTIPLE ||
                         r.cmd.op == lsau_pkg::OP_STORE_MULTIPLE) && r.cmd.writeback) begin
                        next_r.wb.we = 1'b1;
                        next_r.wb.idx = r.cmd.base_reg;
                        next_r.wb.data = r.final_addr;
                    end
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.state = lsau_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops; flags never written
    assign o_busy = r.busy;
    assign o_done = r.done;
    assign o_mem = r.mem;
    assign o_wb = r.wb;
    assign o_branch = r.branch;
    assign o_branch_target = r.branch_target;
    assign o_flags_we = 1'b0;
endmodule

// ===== verif/lsau_mem_model.sv
// Behavioural memory on the far side of the unit's data bus
`timescale 1ns/10ps
module lsau_mem_model (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire lsau_pkg::lsau_mem_type i_mem,
    input wire logic [3:0] i_delay,
    input wire logic [31:0] i_seed,
    output logic o_ready,
    output logic o_rdata_valid,
    output logic [31:0] o_rdata
);
    logic [3:0] wait_cnt;
    logic [3:0] lat_cnt;
    logic pend;
    logic [31:0] pend_addr;

    // Stalls i_delay cycles, answers reads i_delay cycles after acceptance
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            {o_ready, o_rdata_valid, o_rdata, wait_cnt, lat_cnt, pend, pend_addr} <= '0;
        end else begin
            o_ready <= 1'b0;
            o_rdata_valid <= 1'b0;
            o_rdata <= ~o_rdata; // Released bus never holds old data
            if (i_mem.req && !o_ready && !pend) begin
                if (wait_cnt >= i_delay) begin
                    o_ready <= 1'b1;
                    wait_cnt <= 4'h0;
                    pend <= !i_mem.write;
                    pend_addr <= i_mem.addr;
                    lat_cnt <= i_delay;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
            if (pend && lat_cnt == 4'h0) begin
                o_rdata_valid <= 1'b1;
                o_rdata <= i_seed + pend_addr;
                pend <= 1'b0;
            end else if (pend) begin
                lat_cnt <= lat_cnt - 4'h1;
            end
        end
    end
endmodule

// ===== verif/lsau_unit_asserts.sv
// Port checker for the load/store address unit
`timescale 1ns/10ps
`include "lsau_params.svh"
module lsau_unit_asserts (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire logic i_cmd_valid,
    input wire lsau_pkg::lsau_cmd_type i_cmd,
    input wire logic i_mem_ready,
    input wire logic i_rdata_valid,
    input wire logic [31:0] i_rdata,
    input wire logic o_busy,
    input wire logic o_done,
    input wire lsau_pkg::lsau_mem_type o_mem,
    input wire lsau_pkg::lsau_wb_type o_wb,
    input wire logic o_branch,
    input wire logic [31:0] o_branch_target,
    input wire logic o_flags_we
);
    lsau_pkg::lsau_cmd_type cmd;
    wire regoff = cmd.op inside {lsau_pkg::OP_LOAD_REGOFF, lsau_pkg::OP_STORE_REGOFF};
    wire unp = cmd.op inside {lsau_pkg::OP_LOAD_UNPRIV, lsau_pkg::OP_STORE_UNPRIV};

    // Keep the accepted command so addresses can be tied to operands
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cmd <= '0;
        end else if (i_cmd_valid && !o_busy) begin
            cmd <= i_cmd;
        end
    end

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);

    flags_never_a: assert property (o_flags_we == 1'b0)
        else $error("flag write seen");
    accept_req_a: assert property (i_cmd_valid && !o_busy |-> ##2 o_mem.req)
        else $error("no request two cycles after accept");
    req_hold_a: assert property (o_mem.req && !i_mem_ready |=> o_mem.req && $stable(o_mem.addr))
        else $error("request dropped or moved before ready");
    regoff_addr_a: assert property (o_mem.req && regoff |->
        o_mem.addr == cmd.base_val + (cmd.offset_val << cmd.shift_left_amount))
        else $error("register offset address wrong");
    unpriv_addr_a: assert property (o_mem.req && unp |->
        o_mem.unpriv && o_mem.addr == cmd.base_val + cmd.offset_val)
        else $error("unprivileged access wrong");
    pcrel_addr_a: assert property (o_mem.req && cmd.op == lsau_pkg::OP_LOAD_PCREL |->
        o_mem.addr == cmd.pc_val + cmd.offset_val)
        else $error("relative address wrong");
    load_result_a: assert property (i_rdata_valid && o_busy &&
        cmd.transfer_reg != `LSAU_REG_PC |=> o_wb.we)
        else $error("no register write after load data");
    regoff_wb_a: assert property (o_wb.we && regoff |-> o_wb.idx == cmd.transfer_reg)
        else $error("register offset wrote another register");
    branch_even_a: assert property (o_branch |-> o_wb.we && o_wb.idx == `LSAU_REG_PC &&
        o_branch_target == (o_wb.data & 32'hffff_fffe))
        else $error("branch not to loaded value with bit0 cleared");

    // Main scenarios reached
    cover property (o_branch);
    cover property (o_mem.req && unp);
    cover property (o_mem.req && o_mem.write && cmd.op == lsau_pkg::OP_STORE_MULTIPLE);
endmodule

bind lsau_unit lsau_unit_asserts lsau_unit_asserts_i (.I_CORE_CLK(I_CORE_CLK),
    .I_RST_B(I_RST_B), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_mem_ready(i_mem_ready),
    .i_rdata_valid(i_rdata_valid), .i_rdata(i_rdata), .o_busy(o_busy), .o_done(o_done),
    .o_mem(o_mem), .o_wb(o_wb), .o_branch(o_branch), .o_branch_target(o_branch_target),
    .o_flags_we(o_flags_we));

// ===== verif/lsau_unit_test.sv
// Self-checking bench for the load/store address unit
`timescale 1ns/10ps
module lsau_unit_test;
    logic I_CORE_CLK = 1'b0;
    logic I_RST_B = 1'b0;
    logic i_cmd_valid = 1'b0;
    lsau_pkg::lsau_cmd_type i_cmd = '0;
    logic [3:0] delay = 4'h0;
    logic [31:0] seed = 32'h0;
    logic i_mem_ready, i_rdata_valid, o_busy, o_done, o_branch, o_flags_we;
    logic [31:0] i_rdata, o_branch_target;
    lsau_pkg::lsau_mem_type o_mem;
    lsau_pkg::lsau_wb_type o_wb;
    lsau_pkg::lsau_mem_type acc_q[$];
    lsau_pkg::lsau_wb_type wb_q[$];
    logic [31:0] br_q[$];
    int errors = 0;
    int n_tests = 0;

    always #5 I_CORE_CLK = ~I_CORE_CLK;

    lsau_unit lsau_unit_i (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .i_mem_ready(i_mem_ready), .i_rdata_valid(i_rdata_valid),
        .i_rdata(i_rdata), .o_busy(o_busy), .o_done(o_done), .o_mem(o_mem), .o_wb(o_wb),
        .o_branch(o_branch), .o_branch_target(o_branch_target), .o_flags_we(o_flags_we));
    lsau_mem_model lsau_mem_model_i (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .i_mem(o_mem),
        .i_delay(delay), .i_seed(seed), .o_ready(i_mem_ready), .o_rdata_valid(i_rdata_valid),
        .o_rdata(i_rdata));

    // Log accepted accesses, register writes and branches
    always @(posedge I_CORE_CLK) begin
        if (o_mem.req && i_mem_ready) acc_q.push_back(o_mem);
        if (o_wb.we) wb_q.push_back(o_wb);
        if (o_branch) br_q.push_back(o_branch_target);
    end

    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return seed + a;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d checks %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One command; the extra edge lets the log settle before judging
    task automatic run(input lsau_pkg::lsau_cmd_type c);
        int k;
        acc_q.delete();
        wb_q.delete();
        br_q.delete();
        k = 0;
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        @(posedge I_CORE_CLK);
        i_cmd_valid <= 1'b0;
        while (o_done !== 1'b1 && k < 300) begin
            @(posedge I_CORE_CLK);
            k++;
        end
        chk(k < 300, 1);
        chk(o_flags_we, 1'b0);
        @(posedge I_CORE_CLK);
    endtask

    // Every shift; the largest one as a store
    task automatic s_regoff();
        lsau_pkg::lsau_cmd_type c;
        logic [31:0] a;
        c = '0;
        c.base_val = 32'h0000_2000;
        c.offset_val = 32'h0000_0010;
        c.transfer_reg = 4'h3;
        c.privileged = 1'b1;
        for (int s = 0; s < 4; s++) begin
            c.shift_left_amount = s[1:0];
            c.op = (s == 3) ? lsau_pkg::OP_STORE_REGOFF : lsau_pkg::OP_LOAD_REGOFF;
            c.store_set_data = 32'h5a5a_0001 + s;
            a = 32'h0000_2000 + (32'h10 << s);
            run(c);
            chk(acc_q[0].addr, a);
            chk(acc_q[0].write, s == 3);
            chk(acc_q[0].unpriv, 1'b0);
            if (s == 3) chk(acc_q[0].wdata, c.store_set_data);
            chk(wb_q.size(), s < 3);
            if (s < 3) chk(wb_q[0].data, mem_word(a));
        end
    endtask

    // Bytes and halfwords with the sign bit set
    task automatic s_extend();
        lsau_pkg::lsau_cmd_type c;
        logic [31:0] e [4] = '{32'h0000_0080, 32'hffff_ff80, 32'h0000_ff80, 32'hffff_ff80};
        c = '0;
        c.base_val = 32'h0000_0100;
        c.transfer_reg = 4'h2;
        seed <= 32'h1234_fe80;
        for (int i = 0; i < 4; i++) begin
            c.size = (i < 2) ? lsau_pkg::SIZE_BYTE : lsau_pkg::SIZE_HALF;
            c.is_signed = i[0];
            run(c);
            chk(wb_q[0].data, e[i]);
            chk(acc_q[0].size, c.size);
        end
    endtask

    // Offsets 255 and 0, privileged and not
    task automatic s_unpriv();
        lsau_pkg::lsau_cmd_type c;
        c = '0;
        c.base_val = 32'h0000_3000;
        c.transfer_reg = 4'h4;
        for (int i = 0; i < 3; i++) begin
            c.op = i[0] ? lsau_pkg::OP_STORE_UNPRIV : lsau_pkg::OP_LOAD_UNPRIV;
            c.privileged = !i[0];
            c.offset_val = (i == 2) ? 32'h0 : 32'hff;
            run(c);
            chk(acc_q[0].addr, 32'h0000_3000 + c.offset_val);
            chk(acc_q[0].unpriv, 1'b1);
        end
    endtask

    // Range ends of both relative forms, then a loaded program counter
    task automatic s_pcrel();
        lsau_pkg::lsau_cmd_type c;
        c = '0;
        c.op = lsau_pkg::OP_LOAD_PCREL;
        c.pc_val = 32'h0001_0000;
        c.offset_val = 32'hffff_f001;
        c.transfer_reg = 4'h5;
        run(c);
        chk(acc_q[0].addr, 32'h0000_f001);
        c.op = lsau_pkg::OP_LOAD_PAIR_PCREL;
        c.offset_val = 32'h0000_03fc;
        c.second_transfer_reg = 4'h6;
        run(c);
        chk(acc_q[1].addr, 32'h0001_0400);
        chk(wb_q[1].idx, 4'h6);
        chk(wb_q[1].data, mem_word(32'h0001_0400));
        c.op = lsau_pkg::OP_LOAD_REGOFF;
        c.transfer_reg = 4'hf;
        seed <= 32'h0800_0001; // Loaded word comes back odd
        run(c); // Unconditional, so no if_then_block ordering applies
        chk(br_q[0], mem_word(32'h0000_03fc) & 32'hffff_fffe);
    endtask

    // Every mode name, writeback on odd entries, memory stalls on some
    task automatic s_multi();
        lsau_pkg::lsau_cmd_type c;
        logic [3:0] regs [3] = '{4'h0, 4'h2, 4'h9};
        logic [31:0] a;
        logic dec, st;
        c = '0;
        c.base_val = 32'h0000_1000;
        c.base_reg = 4'h7;
        c.register_set = 16'h0205;
        c.store_set_data = 32'hc0de_0042;
        for (int m = 0; m < 7; m++) begin
            c.mode = lsau_pkg::lsau_mode_type'(m);
            dec = m inside {2, 4, 6};
            st = m inside {5, 6};
            c.op = st ? lsau_pkg::OP_STORE_MULTIPLE : lsau_pkg::OP_LOAD_MULTIPLE;
            c.writeback = m[0];
            delay <= {2'h0, m[1], 1'b0};
            run(c);
            chk(acc_q.size(), 3);
            for (int k = 0; k < 3; k++) begin
                a = dec ? 32'h1000 - 4 * k : 32'h1000 + 4 * k;
                chk(acc_q[k].addr, a);
                chk(acc_q[k].write, st);
                chk(acc_q[k].size, lsau_pkg::SIZE_WORD);
                if (st) chk(acc_q[k].wdata, c.store_set_data);
                if (!st) chk(wb_q[k].idx, regs[dec ? 2 - k : k]);
                if (!st) chk(wb_q[k].data, mem_word(a));
            end
            chk(wb_q.size(), (st ? 0 : 3) + m[0]);
            if (m[0]) chk(wb_q[wb_q.size() - 1].data, dec ? 32'h0ff8 : 32'h1008);
        end
    endtask

    initial begin
        repeat (10) @(posedge I_CORE_CLK);
        I_RST_B <= 1'b1;
        @(posedge I_CORE_CLK);
        s_regoff();
        s_extend();
        s_unpriv();
        s_pcrel();
        s_multi();
        report_and_stop();
    end

    // Twenty-one commands need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge I_CORE_CLK);
        errors++;
        report_and_stop();
    end
endmodule
